// >>> rtl/ufl_pkg.sv
// constants for the microframe length adjust block
package ufl_pkg;

  // configuration dword that holds release number, adjust byte, wake mask
  localparam logic [7:0] UFL_OFS_RELEASE     = 8'h60;
  localparam logic [7:0] UFL_OFS_FRAME_ADJ   = 8'h61;
  localparam logic [7:0] UFL_OFS_WAKE_MASK   = 8'h62;
  localparam logic [5:0] UFL_DWORD_EHCI      = UFL_OFS_RELEASE[7:2];

  // byte lanes inside that dword
  localparam int         UFL_LANE_ADJ        = 1;
  localparam int         UFL_LANE_MASK_LO    = 2;
  localparam int         UFL_LANE_MASK_HI    = 3;

  // field layout of the adjust byte
  localparam int         UFL_ADJ_VAL_MSB     = 5;
  localparam int         UFL_ADJ_VAL_W       = 6;

  // reset values
  localparam logic [7:0]  UFL_RST_FRAME_ADJ  = 8'h20;
  localparam logic [15:0] UFL_RST_WAKE_MASK  = 16'h001F;

  // microframe length in bit times is base plus step times value
  localparam logic [15:0] UFL_LEN_BASE       = 16'hE860; // 59488
  localparam int          UFL_LEN_STEP_SHIFT = 4;        // 16 bit times

  // bit-time rate against system clock rate, in whole MHz
  localparam int          UFL_BIT_MHZ        = 480;
  localparam int          UFL_CLK_MHZ        = 200;
  localparam int          UFL_RATE_GCD       = 40;
  // phase units: one bit time is UFL_PH_PER_BIT units,
  // one system clock advances UFL_PH_PER_CLK units
  localparam int          UFL_PH_PER_BIT_I   = UFL_CLK_MHZ / UFL_RATE_GCD;
  localparam int          UFL_PH_PER_CLK_I   = UFL_BIT_MHZ / UFL_RATE_GCD;
  localparam int          UFL_PH_W           = 20;
  localparam logic [UFL_PH_W-1:0] UFL_PH_PER_BIT = UFL_PH_PER_BIT_I[UFL_PH_W-1:0];
  localparam logic [UFL_PH_W-1:0] UFL_PH_PER_CLK = UFL_PH_PER_CLK_I[UFL_PH_W-1:0];

endpackage : ufl_pkg

// >>> rtl/ufl_sof_counter.sv
// start-of-frame counter paced in high-speed bit times
`timescale 1ns/1ps
`default_nettype none
module ufl_sof_counter
  import ufl_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // programmed adjust value
  input  wire logic [5:0]  frame_length_value_i,
  // microframe timing
  output logic             uframe_start_o,
  output logic [15:0]      uframe_len_o
);

  logic [UFL_PH_W-1:0] phase;
  logic [UFL_PH_W-1:0] limit;
  logic [UFL_PH_W-1:0] next_phase;
  logic [15:0]         next_len;
  logic [UFL_PH_W-1:0] next_limit;
  // length that belongs to the reset value of the adjust field
  localparam logic [15:0] RST_LEN = UFL_LEN_BASE
    + {6'h00, UFL_RST_FRAME_ADJ[UFL_ADJ_VAL_MSB:0], 4'h0};

  // length in bit times for the value now programmed
  always_comb begin
    next_len   = UFL_LEN_BASE
               + {6'h00, frame_length_value_i, 4'h0};
    next_limit = UFL_PH_W'(next_len) * UFL_PH_PER_BIT;
    next_phase = phase + UFL_PH_PER_CLK;
  end

  // the 480 MHz bit clock is tracked as a fractional phase on clk_sys_i
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      phase          <= '0;
      limit          <= UFL_PH_W'(RST_LEN) * UFL_PH_PER_BIT;
      uframe_len_o   <= RST_LEN;
      uframe_start_o <= 1'b0;
    end else if (next_phase >= limit) begin
      phase          <= next_phase - limit;
      limit          <= next_limit;
      uframe_len_o   <= next_len;
      uframe_start_o <= 1'b1;
    end else begin
      phase          <= next_phase;
      uframe_start_o <= 1'b0;
    end
  end

endmodule : ufl_sof_counter
`default_nettype wire

// >>> rtl/ufl_frame_adjust.sv
// configuration registers for microframe length and port wake mask
`timescale 1ns/1ps
`default_nettype none
//Contract
// - microframe lasts 59488 plus adjust value steps
// - each adjust step is 16 bit times
// - adjust value resets to 32, 60000 counts
// - written adjust value changes frame length
// - counter counts 480 MHz bit times
// - wake mask at 62h, resets 001Fh
// - wake mask only stores, no effect
// - mask bits 15..1 map to ports
// - registers sit in configuration space at 61h to 63h
module ufl_frame_adjust
  import ufl_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // configuration space access
  input  wire logic        cfg_rd_i,
  input  wire logic        cfg_wr_i,
  input  wire logic [5:0]  cfg_dword_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic [31:0]      cfg_rdata_o,
  output logic             cfg_ack_o,
  // register contents
  output logic [5:0]       frame_length_value_o,
  output logic [15:0]      port_wake_mask_o,
  // microframe timing
  output logic             uframe_start_o,
  output logic [15:0]      uframe_len_o
);

  logic [7:0]  frame_length_adjust;
  logic [15:0] port_wake_mask;
  logic        hit;
  logic [31:0] read_word;

  assign hit = (cfg_dword_i == UFL_DWORD_EHCI);

  // adjust byte: all eight bits are read/write
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      frame_length_adjust <= UFL_RST_FRAME_ADJ;
    end else if (cfg_wr_i && hit && cfg_be_i[UFL_LANE_ADJ]) begin
      frame_length_adjust <= cfg_wdata_i[UFL_LANE_ADJ*8 +: 8];
    end
  end

  // wake mask: stored for software only, steers nothing here
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      port_wake_mask <= UFL_RST_WAKE_MASK;
    end else if (cfg_wr_i && hit) begin
      if (cfg_be_i[UFL_LANE_MASK_LO]) begin
        port_wake_mask[7:0]  <= cfg_wdata_i[UFL_LANE_MASK_LO*8 +: 8];
      end
      if (cfg_be_i[UFL_LANE_MASK_HI]) begin
        port_wake_mask[15:8] <= cfg_wdata_i[UFL_LANE_MASK_HI*8 +: 8];
      end
    end
  end

  // release number byte belongs to another block and reads zero here
  always_comb begin
    read_word = 32'h0000_0000;
    if (hit) begin
      read_word[UFL_LANE_ADJ*8 +: 8]     = frame_length_adjust;
      read_word[UFL_LANE_MASK_LO*8 +: 8] = port_wake_mask[7:0];
      read_word[UFL_LANE_MASK_HI*8 +: 8] = port_wake_mask[15:8];
    end
  end

  // every access is answered one cycle later; other dwords read zero
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg_ack_o   <= 1'b0;
      cfg_rdata_o <= 32'h0000_0000;
    end else begin
      cfg_ack_o   <= cfg_rd_i | cfg_wr_i;
      if (cfg_rd_i) begin
        cfg_rdata_o <= read_word;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      frame_length_value_o <= UFL_RST_FRAME_ADJ[UFL_ADJ_VAL_MSB:0];
      port_wake_mask_o     <= UFL_RST_WAKE_MASK;
    end else begin
      frame_length_value_o <= frame_length_adjust[UFL_ADJ_VAL_MSB:0];
      port_wake_mask_o     <= port_wake_mask;
    end
  end

  ufl_sof_counter u_sof (
    .clk_sys_i            (clk_sys_i),
    .rst_i                (rst_i),
    .frame_length_value_i (frame_length_adjust[UFL_ADJ_VAL_MSB:0]),
    .uframe_start_o       (uframe_start_o),
    .uframe_len_o         (uframe_len_o)
  );

endmodule : ufl_frame_adjust
`default_nettype wire

// >>> testbench/ufl_chk_sva.sv
// assertions on the config port and microframe timing
`timescale 1ns/1ps
`default_nettype none
module ufl_chk (
  input wire logic        clk_sys_i, rst_i, cfg_rd_i, cfg_wr_i, cfg_ack_o,
  input wire logic        uframe_start_o,
  input wire logic [5:0]  cfg_dword_i, frame_length_value_o,
  input wire logic [3:0]  cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [15:0] port_wake_mask_o, uframe_len_o
);
  logic [15:0] gap;
  wire logic wa = cfg_wr_i && cfg_dword_i == 6'h18;
  // cycles since the last boundary or reset
  always_ff @(posedge clk_sys_i) begin
    gap <= (rst_i | uframe_start_o) ? 16'h1 : gap + 16'h1;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property ((cfg_rd_i | cfg_wr_i) |=> cfg_ack_o)
    else $error("no ack");
  a_len_range: assert property (uframe_start_o |->
    uframe_len_o[3:0] == 4'h0 && uframe_len_o inside {[16'hE860:16'hEC50]})
    else $error("bad length");
  a_len_holds: assert property (!uframe_start_o |-> $stable(uframe_len_o))
    else $error("length moved");
  a_start_pulse: assert property (uframe_start_o |=> !uframe_start_o)
    else $error("long pulse");
  a_frame_gap: assert property (uframe_start_o |->
    gap inside {[16'd24785:16'd25208]}) else $error("bad spacing");
  a_reset_vals: assert property ($fell(rst_i) |->
    frame_length_value_o == 6'h20 && port_wake_mask_o == 16'h001F
    && uframe_len_o == 16'd60000) else $error("bad reset");
  a_adj_write: assert property (wa && cfg_be_i[1] |=> ##1
    frame_length_value_o == $past(cfg_wdata_i[13:8], 2)) else $error("adj");
  a_mask_write: assert property (wa && cfg_be_i[2] |=> ##1
    port_wake_mask_o[7:0] == $past(cfg_wdata_i[23:16], 2)) else $error("mask");
  c_frame: cover property (uframe_start_o);
  c_adj: cover property (wa && cfg_be_i[1]);
  c_read: cover property (cfg_rd_i ##1 cfg_ack_o);
  c_mask: cover property (wa && cfg_be_i[3]);
endmodule : ufl_chk
`default_nettype wire

// >>> testbench/ufl_cfg_host.sv
// configuration host model driving the config port
`timescale 1ns/1ps
`default_nettype none
module ufl_cfg_host (
  input wire logic        clk_sys_i, cfg_ack_o,
  input wire logic [31:0] cfg_rdata_o,
  output logic            cfg_rd_i, cfg_wr_i,
  output logic [5:0]      cfg_dword_i,
  output logic [3:0]      cfg_be_i,
  output logic [31:0]     cfg_wdata_i
);
  initial {cfg_rd_i, cfg_wr_i, cfg_dword_i, cfg_be_i, cfg_wdata_i} = '0;
  task xfer(input logic w, input logic [5:0] d, input logic [3:0] b,
            input logic [31:0] x, output logic [31:0] r, output logic ok);
    @(posedge clk_sys_i) #1;
    {cfg_wr_i, cfg_rd_i, cfg_dword_i, cfg_be_i} = {w, !w, d, b};
    cfg_wdata_i = x & 32'hFFFF3FFF;
    @(posedge clk_sys_i) #1;
    {cfg_wr_i, cfg_rd_i} = 2'b00;
    cfg_wdata_i = ~cfg_wdata_i;
    ok = cfg_ack_o === 1'b1;
    r = cfg_rdata_o;
  endtask : xfer
endmodule : ufl_cfg_host
`default_nettype wire

// >>> testbench/ufl_frame_adjust_bench.sv
// bench for the microframe length adjust block
`timescale 1ns/1ps
`default_nettype none
module ufl_frame_adjust_bench;
  logic clk_sys_i = 0, rst_i = 1, cfg_rd_i, cfg_wr_i, cfg_ack_o, ok;
  logic        uframe_start_o;
  logic [5:0]  cfg_dword_i, frame_length_value_o, d;
  logic [3:0]  cfg_be_i;
  logic [31:0] cfg_wdata_i, cfg_rdata_o, rd, lf = 32'h30A8;
  logic [15:0] port_wake_mask_o, uframe_len_o, msk = 16'h001F;
  logic [7:0]  adj = 8'h20;
  int err_total = 0, n_checks = 0;
  ufl_frame_adjust u_ufl_frame_adjust (.*);
  ufl_cfg_host u_ufl_cfg_host (.*);
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  function automatic logic [31:0] ev(logic [5:0] a);
    return (a == 6'h18) ? {msk, adj, 8'h00} : 32'h0;
  endfunction : ev
  task chk(logic [31:0] g, logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task acc(logic w, logic [5:0] a, logic [3:0] b, logic [31:0] x);
    u_ufl_cfg_host.xfer(w, a, b, x, rd, ok);
    chk({31'h0, ok}, 32'h1);
  endtask : acc
  // wait for a boundary, then compare the new length
  task frame(logic [15:0] len);
    int i;
    for (i = 0; i < 26000 && uframe_start_o !== 1'b1; i++) @(posedge clk_sys_i) #1;
    if (i == 26000) begin
      err_total++;
      give_verdict();
    end
    chk({16'h0, uframe_len_o}, {16'h0, len});
    @(posedge clk_sys_i) #1;
  endtask : frame
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  initial begin
    repeat (2) @(posedge clk_sys_i);
    #1 rst_i = 0;
    acc(0, 6'h18, 4'h0, 0);
    chk(rd, ev(6'h18));
    frame(16'd60000);
    acc(1, 6'h18, 4'h2, 32'h0000C000);
    frame(16'd59488);
    acc(1, 6'h18, 4'h2, 32'h00003F00);
    frame(16'd59488 + 16'd1008);
    adj = 8'h3F;
    for (int k = 0; k < 40; k++) begin
      lf = nx(lf);
      d = lf[6] ? 6'h18 : lf[5:0];
      acc(1, d, lf[11:8], lf);
      if (d == 6'h18 && lf[9]) adj = {2'b00, lf[13:8]};
      if (d == 6'h18 && lf[10]) msk[7:0] = lf[23:16];
      if (d == 6'h18 && lf[11]) msk[15:8] = lf[31:24];
      acc(0, d, 4'h0, 0);
      chk(rd, ev(d));
    end
    give_verdict();
  end
endmodule : ufl_frame_adjust_bench
bind ufl_frame_adjust ufl_chk u_ufl_chk (.*);
`default_nettype wire
